// ==== common/vsp_pkg.sv ====
// Constants, types and decode helpers for the variable store and port map.
// Assumes a single 50 MHz core clock and a 12-bit APB byte address.
package vsp_pkg;

  // Sizes of the general variable views and the storage memory
  localparam int unsigned GP_BYTES = 14;
  localparam int unsigned GP_WORDS = 7;
  localparam int unsigned FLAG_BITS = 16;
  localparam int unsigned STORE_DEPTH = 96;

  // Storage byte address windows
  localparam logic [7:0] STORE_LO_FIRST = 8'h50;
  localparam logic [7:0] STORE_LO_LAST = 8'h7f;
  localparam logic [7:0] STORE_HI_FIRST = 8'hc0;
  localparam logic [7:0] STORE_HI_LAST = 8'hef;
  localparam logic [6:0] STORE_LO_COUNT = 7'h30;

  // APB byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_PORT = 12'h004;
  localparam logic [11:0] OFS_DIR = 12'h008;
  localparam logic [11:0] OFS_PORT_COPY = 12'h00c;
  localparam logic [11:0] OFS_IR = 12'h010;
  localparam logic [11:0] OFS_ARITH = 12'h014;
  localparam logic [11:0] OFS_BYTE_BASE = 12'h040;
  localparam logic [11:0] OFS_WORD_BASE = 12'h080;
  localparam logic [11:0] OFS_BIT_BASE = 12'h0c0;
  localparam logic [11:0] OFS_STORE_BASE = 12'h400;

  // Field positions
  localparam int unsigned CTRL_CLEAR_BIT = 0;
  localparam int unsigned CTRL_VARIANT_LSB = 4;
  localparam int unsigned ARITH_SUB_BIT = 16;
  localparam int unsigned ARITH_OPND_LSB = 8;

  // Reset values
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] GP_RESET = 8'h00;

  typedef enum logic [2:0] {
    VSP_V8, VSP_V8M, VSP_V18, VSP_V18X, VSP_V28A, VSP_V28X
  } vsp_variant_t;

  localparam vsp_variant_t VARIANT_RESET = VSP_V28X;

  // Implemented input bits per package size
  function automatic logic [7:0] vsp_in_mask(input vsp_variant_t v);
    if (v == VSP_V8 || v == VSP_V8M)
      return 8'h1e;
    else if (v == VSP_V18 || v == VSP_V18X)
      return 8'hc7;
    else
      return 8'hff;
  endfunction

  // Implemented direction bits; only the small package has them
  function automatic logic [7:0] vsp_dir_mask(input vsp_variant_t v);
    if (v == VSP_V8 || v == VSP_V8M)
      return 8'h16;
    else
      return 8'h00;
  endfunction

  // Storage address to {hit, row}
  function automatic logic [7:0] vsp_store_map(input vsp_variant_t v, input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (v != VSP_V8 && a >= STORE_LO_FIRST && a <= STORE_LO_LAST)
      r = {1'b1, a[6:0] - STORE_LO_FIRST[6:0]};
    else if ((v == VSP_V18X || v == VSP_V28X) && a >= STORE_HI_FIRST && a <= STORE_HI_LAST)
      r = {1'b1, 7'(a - STORE_HI_FIRST) + STORE_LO_COUNT};
    return r;
  endfunction

endpackage

// ==== common/vsp_if.sv ====
// Carriers between the top and its storage memory and port map.
// Assumes all members are sampled on core_clk.
interface vsp_mem_if;
  logic [6:0] row;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctl (output row, output we, output wdata, input rdata);
  modport mem (input row, input we, input wdata, output rdata);
endinterface

interface vsp_port_if;
  vsp_pkg::vsp_variant_t variant;
  logic wr_port;
  logic wr_dir;
  logic copy;
  logic [7:0] wdata;
  logic [7:0] pin_read;
  logic [7:0] out_latch;
  logic [7:0] dir;
  modport ctl (output variant, output wr_port, output wr_dir, output copy, output wdata,
               input pin_read, input out_latch, input dir);
  modport port (input variant, input wr_port, input wr_dir, input copy, input wdata,
                output pin_read, output out_latch, output dir);
endinterface

// ==== verilog/vsp_store_mem.sv ====
// Storage byte memory, written and read by row.
// Assumes row is already decoded; read data are registered.
module vsp_store_mem
(
  // Clock
  input wire logic core_clk,
  // Access
  vsp_mem_if.mem bus
);

  logic [7:0] mem [vsp_pkg::STORE_DEPTH];

  // Contents survive reset, as plain RAM would
  always_ff @(posedge core_clk)
  begin
    if (bus.we)
      mem[bus.row] <= bus.wdata;
  end

  always_ff @(posedge core_clk)
  begin
    bus.rdata <= mem[bus.row];
  end

endmodule

// ==== verilog/vsp_port_map.sv ====
// Output latch, direction register and input sampler of the I/O port.
// Assumes strobes are one-cycle pulses from the register decoder.
module vsp_port_map
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Pins
  input wire logic [7:0] pin_in,
  // Control side
  vsp_port_if.port pif
);

  logic [7:0] pin_sample;

  always_ff @(posedge core_clk)
  begin
    if (srst)
      pin_sample <= 8'h00;
    else
      pin_sample <= pin_in;
  end

  // Unimplemented positions read as zero
  assign pif.pin_read = pin_sample & vsp_pkg::vsp_in_mask(pif.variant);

  always_ff @(posedge core_clk)
  begin
    if (srst)
      pif.out_latch <= vsp_pkg::PORT_RESET;
    else if (pif.copy)
      pif.out_latch <= pif.pin_read;
    else if (pif.wr_port)
      pif.out_latch <= pif.wdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      pif.dir <= vsp_pkg::DIR_RESET;
    else if (pif.wr_dir)
      pif.dir <= pif.wdata & vsp_pkg::vsp_dir_mask(pif.variant);
  end

endmodule

// ==== verilog/vsp_top.sv ====
// Variable store and port map: general variables, storage bytes and port.
// Assumes an APB3 master on core_clk; pin inputs are synchronous.
//
// Chosen here: the placing of the registers and the APB slave port.
module vsp_top
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_dir
);

  typedef enum logic [3:0] {
    VSP_D_NONE, VSP_D_CTRL, VSP_D_PORT, VSP_D_DIR, VSP_D_COPY, VSP_D_IR,
    VSP_D_ARITH, VSP_D_BYTE, VSP_D_WORD, VSP_D_BIT, VSP_D_STORE
  } vsp_dec_t;

  vsp_mem_if mif ();
  vsp_port_if pif ();

  logic [7:0] gp [vsp_pkg::GP_BYTES];
  logic [7:0] ir_byte;
  logic [7:0] arith_result;
  vsp_pkg::vsp_variant_t variant;
  logic clear_req;
  vsp_dec_t dec;
  logic [3:0] dec_idx;
  logic [7:0] store_map;
  logic commit;
  logic wr;
  logic [31:0] next_rdata;
  logic next_err;
  logic [3:0] ar_idx;
  logic [7:0] ar_opnd;
  logic [7:0] ar_sum;
  logic ir_alias;

  vsp_store_mem u_mem
  (
    .core_clk(core_clk),
    .bus(mif.mem)
  );

  vsp_port_map u_port
  (
    .core_clk(core_clk),
    .srst(srst),
    .pin_in(pin_in),
    .pif(pif.port)
  );

  // Storage decode uses the raw address byte of the peek/poke window
  assign store_map = vsp_pkg::vsp_store_map(variant, paddr[9:2]);

  // Address decode
  always_comb
  begin
    dec = VSP_D_NONE;
    dec_idx = paddr[5:2];
    if (paddr[1:0] != 2'b00)
      dec = VSP_D_NONE;
    else if (paddr >= vsp_pkg::OFS_STORE_BASE)
    begin
      if (store_map[7])
        dec = VSP_D_STORE;
    end
    else if (paddr == vsp_pkg::OFS_CTRL)
      dec = VSP_D_CTRL;
    else if (paddr == vsp_pkg::OFS_PORT)
      dec = VSP_D_PORT;
    else if (paddr == vsp_pkg::OFS_DIR)
      dec = VSP_D_DIR;
    else if (paddr == vsp_pkg::OFS_PORT_COPY)
      dec = VSP_D_COPY;
    else if (paddr == vsp_pkg::OFS_IR)
      dec = VSP_D_IR;
    else if (paddr == vsp_pkg::OFS_ARITH)
      dec = VSP_D_ARITH;
    else if (paddr >= vsp_pkg::OFS_BYTE_BASE && paddr < vsp_pkg::OFS_WORD_BASE)
    begin
      if (32'(dec_idx) < vsp_pkg::GP_BYTES)
        dec = VSP_D_BYTE;
    end
    else if (paddr >= vsp_pkg::OFS_WORD_BASE && paddr < vsp_pkg::OFS_BIT_BASE)
    begin
      if (32'(dec_idx) < vsp_pkg::GP_WORDS)
        dec = VSP_D_WORD;
    end
    else if (paddr >= vsp_pkg::OFS_BIT_BASE && paddr < 12'h100)
      dec = VSP_D_BIT;
  end

  // A write lands at the edge where the master sees pready high
  assign commit = psel && penable && pready;
  assign wr = commit && pwrite && !pslverr;

  // Small parts keep the infrared result in byte 13
  assign ir_alias = (variant == vsp_pkg::VSP_V8) || (variant == vsp_pkg::VSP_V8M);

  // Arithmetic only ever names a general byte, never storage
  assign ar_idx = pwdata[3:0];
  assign ar_opnd = pwdata[vsp_pkg::ARITH_OPND_LSB +: 8];
  // Eight-bit sum drops the carry on purpose
  assign ar_sum = pwdata[vsp_pkg::ARITH_SUB_BIT] ? 8'(gp[ar_idx] - ar_opnd)
                                                  : 8'(gp[ar_idx] + ar_opnd);

  // General variables: one array behind byte, word and bit views
  always_ff @(posedge core_clk)
  begin
    if (srst || clear_req)
    begin
      for (int i = 0; i < vsp_pkg::GP_BYTES; i++)
        gp[i] <= vsp_pkg::GP_RESET;
    end
    else if (wr)
    begin
      case (dec)
        VSP_D_BYTE:
          gp[dec_idx] <= pwdata[7:0];
        VSP_D_WORD:
        begin
          gp[{dec_idx[2:0], 1'b1}] <= pwdata[15:8];
          gp[{dec_idx[2:0], 1'b0}] <= pwdata[7:0];
        end
        VSP_D_BIT:
          gp[{3'b000, dec_idx[3]}][dec_idx[2:0]] <= pwdata[0];
        VSP_D_ARITH:
        begin
          if (32'(ar_idx) < vsp_pkg::GP_BYTES)
            gp[ar_idx] <= ar_sum;
        end
        VSP_D_IR:
        begin
          if (ir_alias)
            gp[13] <= pwdata[7:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Separate infrared byte; the key-value name maps here too
  always_ff @(posedge core_clk)
  begin
    if (srst || clear_req)
      ir_byte <= vsp_pkg::GP_RESET;
    else if (wr && dec == VSP_D_IR && !ir_alias)
      ir_byte <= pwdata[7:0];
  end

  // Last arithmetic result, readable back
  always_ff @(posedge core_clk)
  begin
    if (srst)
      arith_result <= 8'h00;
    else if (wr && dec == VSP_D_ARITH && 32'(ar_idx) < vsp_pkg::GP_BYTES)
      arith_result <= ar_sum;
  end

  // Package size select; program-reset request is a one-cycle pulse
  always_ff @(posedge core_clk)
  begin
    if (srst)
      variant <= vsp_pkg::VARIANT_RESET;
    else if (wr && dec == VSP_D_CTRL && pwdata[vsp_pkg::CTRL_VARIANT_LSB +: 3] <= 3'h5)
      variant <= vsp_pkg::vsp_variant_t'(pwdata[vsp_pkg::CTRL_VARIANT_LSB +: 3]);
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      clear_req <= 1'b0;
    else
      clear_req <= wr && dec == VSP_D_CTRL && pwdata[vsp_pkg::CTRL_CLEAR_BIT];
  end

  // Storage memory access
  assign mif.row = store_map[6:0];
  assign mif.we = wr && dec == VSP_D_STORE;
  assign mif.wdata = pwdata[7:0];

  // Port strobes
  assign pif.variant = variant;
  assign pif.wr_port = wr && dec == VSP_D_PORT;
  assign pif.wr_dir = wr && dec == VSP_D_DIR;
  assign pif.copy = wr && dec == VSP_D_COPY;
  assign pif.wdata = pwdata[7:0];

  // Read mux
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (dec)
      VSP_D_CTRL:
        next_rdata[vsp_pkg::CTRL_VARIANT_LSB +: 3] = variant;
      VSP_D_PORT:
        next_rdata[7:0] = pif.pin_read;
      VSP_D_DIR:
        next_rdata[7:0] = pif.dir;
      VSP_D_COPY:
        next_rdata[7:0] = pif.out_latch;
      VSP_D_IR:
        next_rdata[7:0] = ir_alias ? gp[13] : ir_byte;
      VSP_D_ARITH:
        next_rdata[7:0] = arith_result;
      VSP_D_BYTE:
        next_rdata[7:0] = gp[dec_idx];
      VSP_D_WORD:
        next_rdata[15:0] = {gp[{dec_idx[2:0], 1'b1}], gp[{dec_idx[2:0], 1'b0}]};
      VSP_D_BIT:
        next_rdata[0] = gp[{3'b000, dec_idx[3]}][dec_idx[2:0]];
      VSP_D_STORE:
        next_rdata[7:0] = mif.rdata;
      default:
        next_err = 1'b1;
    endcase
  end

  // One wait state gives the storage memory its registered read
  always_ff @(posedge core_clk)
  begin
    if (srst)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= next_err;
    end
    else
    begin
      pslverr <= 1'b0;
    end
  end

  // Pin outputs, registered copies of the port state
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pin_out <= vsp_pkg::PORT_RESET;
      pin_dir <= vsp_pkg::DIR_RESET;
    end
    else
    begin
      pin_out <= pif.out_latch;
      pin_dir <= pif.dir;
    end
  end

endmodule

// ==== verification/vsp_top_monitor.sv ====
// Port checker for the variable store top.
// Assumes it is bound to vsp_top and sees only its ports.
module vsp_top_monitor
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // APB
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_dir
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence s_wait;
    psel && penable && !pready;
  endsequence

  sequence s_port_commit;
    pready && pwrite && !pslverr && paddr == vsp_pkg::OFS_PORT;
  endsequence

  a_ready_next: assert property (s_wait |=> pready)
    else $error("pready not one cycle after first access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_misalign_err: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_write_rdata_zero: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
    else $error("write returned read data");
  a_port_to_pins: assert property (s_port_commit |-> ##2 pin_out == $past(pwdata[7:0], 2))
    else $error("port write not on pins");
  a_dir_unimpl_zero: assert property (pin_dir[7:5] == 3'b000 && !pin_dir[3] && !pin_dir[0])
    else $error("unimplemented direction bit set");
endmodule

bind vsp_top vsp_top_monitor i_mon (.core_clk(core_clk), .srst(srst), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_dir(pin_dir));

// ==== verification/vsp_core_model.sv ====
// Interpreter core model: the APB master that runs the user program.
// Assumes xfer is entered just after a rising edge; every wait is bounded.
module vsp_core_model
(
  // Clock
  input wire logic core_clk,
  // APB master
  output logic [11:0] paddr = 12'h000,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [31:0] pwdata = 32'h0000_0000,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err, output bit tmo);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    tmo = (n >= 50);
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following request never lands in the same step
    @(posedge core_clk);
  endtask
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the variable store and port map.
// Assumes the core model drives APB and this bench drives the pins.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] BY = vsp_pkg::OFS_BYTE_BASE;
  localparam logic [11:0] ST = vsp_pkg::OFS_STORE_BASE;
  localparam logic [11:0] WD = vsp_pkg::OFS_WORD_BASE;
  localparam logic [11:0] BT = vsp_pkg::OFS_BIT_BASE;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] pin_in = 8'h00;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pin_out;
  logic [7:0] pin_dir;
  int mismatches = 0;
  int num_checks = 0;
  int sa[8] = '{80, 127, 192, 239, 79, 128, 191, 240};
  logic [7:0] vt[3][3] = '{'{8'h50, 8'hff, 8'h00}, '{8'h20, 8'hc7, 8'h00},
                           '{8'h00, 8'h1e, 8'h16}};

  vsp_core_model i_core (.core_clk(core_clk), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  vsp_top i_dut (.core_clk(core_clk), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_dir(pin_dir));

  initial forever #10 core_clk = ~core_clk;

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_data(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_err(input logic [11:0] a, input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error pslverr at %h expected %b seen %b", a, e, g);
    end
  endtask

  // One transfer; reads compare data, all compare the error flag
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic ee);
    logic [31:0] q;
    logic err;
    bit tmo;
    i_core.xfer(w, a, d, q, err, tmo);
    if (tmo)
    begin
      mismatches++;
      results();
    end
    else
    begin
      chk_err(a, ee, err);
      if (!w)
        chk_data($sformatf("reg %h", a), e, q);
    end
  endtask

  function automatic logic [7:0] bv(input int k);
    return 8'(17 * k + 1);
  endfunction

  initial
  begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    pin_in <= 8'ha5;
    @(posedge core_clk);
    for (int k = 0; k < 14; k++)
      acc(0, BY + 12'(4 * k), 0, 0, 0);
    for (int k = 0; k < 14; k++)
      acc(1, BY + 12'(4 * k), 32'(bv(k)), 0, 0);
    for (int k = 0; k < 7; k++)
      acc(0, WD + 12'(4 * k), 0, 32'({bv(2 * k + 1), bv(2 * k)}), 0);
    for (int n = 0; n < 16; n++)
      acc(0, BT + 12'(4 * n), 0, 32'(({bv(1), bv(0)} >> n) & 16'h0001), 0);
    acc(1, vsp_pkg::OFS_BIT_BASE + 12'h03c, 1, 0, 0);
    acc(0, BY + 12'h004, 0, 32'h0000_0092, 0);
    acc(1, vsp_pkg::OFS_WORD_BASE + 12'h018, 32'h0000_beef, 0, 0);
    acc(0, BY + 12'h030, 0, 32'h0000_00ef, 0);
    acc(0, BY + 12'h034, 0, 32'h0000_00be, 0);
    acc(1, BY + 12'h008, 254, 0, 0);
    acc(1, vsp_pkg::OFS_ARITH, 32'h0000_0302, 0, 0);
    acc(0, BY + 12'h008, 0, 1, 0);
    acc(1, BY + 12'h008, 2, 0, 0);
    acc(1, vsp_pkg::OFS_ARITH, 32'h0001_0302, 0, 0);
    acc(0, BY + 12'h008, 0, 255, 0);
    acc(0, vsp_pkg::OFS_ARITH, 0, 255, 0);
    // Index 14 is past the general bytes, so nothing may change
    acc(1, vsp_pkg::OFS_ARITH, 32'h0000_010e, 0, 0);
    acc(0, vsp_pkg::OFS_ARITH, 0, 255, 0);
    acc(1, vsp_pkg::OFS_CTRL, 32'h0000_0051, 0, 0);
    acc(0, BY + 12'h034, 0, 0, 0);
    acc(0, vsp_pkg::OFS_WORD_BASE, 0, 0, 0);
    for (int i = 0; i < 8; i++)
      acc(1, ST + 12'(4 * sa[i]), sa[i], 0, i > 3);
    for (int i = 0; i < 8; i++)
      acc(0, ST + 12'(4 * sa[i]), 0, i > 3 ? 0 : sa[i], i > 3);
    acc(1, vsp_pkg::OFS_CTRL, 32'h0000_0020, 0, 0);
    acc(0, ST + 12'(4 * 80), 0, 80, 0);
    acc(0, ST + 12'(4 * 192), 0, 0, 1);
    acc(1, vsp_pkg::OFS_CTRL, 32'h0000_0000, 0, 0);
    acc(0, ST + 12'(4 * 80), 0, 0, 1);
    acc(0, 12'h020, 0, 0, 1);
    acc(1, BY + 12'h001, 1, 0, 1);
    acc(1, vsp_pkg::OFS_PORT, 32'h0000_00c3, 0, 0);
    repeat (2) @(posedge core_clk);
    chk_data("pin_out", 32'h0000_00c3, 32'(pin_out));
    for (int v = 0; v < 3; v++)
    begin
      acc(1, vsp_pkg::OFS_CTRL, 32'(vt[v][0]), 0, 0);
      acc(1, vsp_pkg::OFS_DIR, 32'h0000_00ff, 0, 0);
      acc(0, vsp_pkg::OFS_DIR, 0, 32'(vt[v][2]), 0);
      acc(0, vsp_pkg::OFS_PORT, 0, 32'(vt[v][1] & 8'ha5), 0);
      acc(1, vsp_pkg::OFS_PORT_COPY, 0, 0, 0);
      repeat (2) @(posedge core_clk);
      chk_data("pin_out", 32'(vt[v][1] & 8'ha5), 32'(pin_out));
      chk_data("pin_dir", 32'(vt[v][2]), 32'(pin_dir));
    end
    // Second pattern reaches pins 1, 3 and 4 that the first leaves low
    pin_in <= 8'h5a;
    @(posedge core_clk);
    acc(0, vsp_pkg::OFS_PORT, 0, 32'h0000_001a, 0);
    acc(1, BY + 12'h034, 32'h0000_005a, 0, 0);
    acc(0, vsp_pkg::OFS_IR, 0, 32'h0000_005a, 0);
    acc(1, vsp_pkg::OFS_CTRL, 32'h0000_0050, 0, 0);
    acc(1, vsp_pkg::OFS_IR, 32'h0000_0033, 0, 0);
    acc(0, BY + 12'h034, 0, 32'h0000_005a, 0);
    acc(0, vsp_pkg::OFS_IR, 0, 32'h0000_0033, 0);
    results();
  end

  // Guard against a hang anywhere in the run
  initial
  begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    results();
  end
endmodule
